// [common/sia_pkg.sv]
package sia_pkg;

  // register indices as seen by the read-only command
  localparam logic [2:0] REG_WAKE = 3'h0;
  localparam logic [2:0] REG_FAIL_A = 3'h1;
  localparam logic [2:0] REG_FAIL_B = 3'h2;

  // positions in the 24-bit flag vector (register index * 8 + bit)
  localparam int BIT_CAN_WAKE = 0;
  localparam int BIT_LIN_WAKE = 1;
  localparam int BIT_WK_PIN_WAKE = 2;
  localparam int BIT_PERIODIC_WAKE = 3;
  localparam int BIT_SUMMARY = 7;
  localparam int BIT_PREWARN = 8;
  localparam int BIT_OT2 = 9;
  localparam int BIT_CAN_OT = 10;
  localparam int BIT_CAN_FAIL = 11;
  localparam int BIT_LIN_FAIL = 12;
  localparam int BIT_UV2 = 16;
  localparam int BIT_UV3 = 17;
  localparam int BIT_OC3 = 18;
  localparam int BIT_SPI_FAIL = 19;
  localparam int BIT_RESET_EVT = 20;
  localparam int BIT_BAD_WDOG = 21;

  localparam int FLAG_W = 24;
  localparam logic [23:0] FLAG_USED = 24'h3f1f0f;
  localparam logic [23:0] FLAG_LATCH = 24'h071f00;
  localparam logic [23:0] FLAG_DUAL = 24'h030000;
  localparam logic [23:0] FLAG_RESET = 24'h000000;
  localparam logic [7:0] RD_RESET = 8'h00;

  // timing, clock 10 MHz
  localparam real MCLK_PERIOD_NS = 100.0;
  localparam real IRQ_TIMEOUT_MIN_MS = 5.4;
  localparam real IRQ_TIMEOUT_MAX_MS = 6.6;
  localparam real IRQ_PULSE_MIN_US = 10.0;
  localparam int IRQ_TO_MAX_CYC = int'($floor(IRQ_TIMEOUT_MAX_MS * 1.0e6 / MCLK_PERIOD_NS));
  localparam int IRQ_GAP_MIN_CYC = int'($ceil(IRQ_TIMEOUT_MIN_MS * 1.0e6 / MCLK_PERIOD_NS));
  localparam int IRQ_PULSE_MIN_CYC = int'($ceil(IRQ_PULSE_MIN_US * 1.0e3 / MCLK_PERIOD_NS));
  localparam int TMR_W = 17;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_ASSERT = 2'b01,
    S_GAP = 2'b10
  } sia_state_e;

  typedef struct packed {
    logic can_wake;
    logic lin_wake;
    logic wk_pin_wake;
    logic periodic_wake;
    logic main_reg_temp_prewarn;
    logic second_reg_overtemp;
    logic can_xcvr_overtemp;
    logic can_fail;
    logic lin_fail;
    logic second_reg_undervolt;
    logic third_reg_undervolt;
    logic third_reg_overcurrent;
    logic spi_fail;
    logic reset_event;
    logic bad_wdog_config;
  } sia_src_s;

  typedef struct packed {
    logic second_on;
    logic third_on;
    logic second_on_cmd;
    logic third_on_cmd;
  } sia_reg_ctl_s;

  typedef struct packed {
    logic strobe;
    logic [2:0] addr;
  } sia_rd_s;

endpackage

// [src/sia_edge_det.sv]
`timescale 1ns/1ps
module sia_edge_det
  import sia_pkg::*;
#(
  parameter int W = 24
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] prev_ff;

  // prev follows live level even when events are gated, so sources rearm
  always_ff @(posedge mclk)
  begin
    if (rst)
      prev_ff <= '0;
    else
      prev_ff <= level;
  end

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_edge
      assign rise[i] = level[i] & ~prev_ff[i];
      assign fall[i] = ~level[i] & prev_ff[i];
    end
  endgenerate

endmodule

// [src/sia_irq_core.sv]
`timescale 1ns/1ps
// Function
// - unmasked source event drives interrupt pin low.
// - each source has its own mask; masked events never assert the pin.
// - undervoltage sources raise events on both appearing and disappearing condition.
// - latched-state bits set at event, hold until read, then show live condition.
// - chip-failure and wake bits are pure events, cleared only by read.
// - pin released on read of register 000 or at timeout.
// - wake bits readable in register 000 and cleared by that read.
// - non-wake sources set summary bit; host reads 001 and 010.
// - read clears event bits of that register; state bits persist while present.
// - summary bit is zero only when all of 001 and 010 are zero.
// - mask zero blocks only the pin; status bit still sets.
// - in init before reset output high, pin sampled to pick configuration group.
// - temperature sources trigger on rising edge; can overtemp is a state bit.
// - chip-failure sources are rising-edge events.
// - regulator switch-off gives no undervoltage event; switch-on command does.
// - assertion at most the timeout; next assertion at least timeout later.
// - each assertion lasts at least ten microseconds.
// - events in the same cycle yield one assertion, all bits kept; an event while asserted re-asserts after the gap.
// - interrupts only in normal and stop modes; sources rearm after restart.
module sia_irq_core
  import sia_pkg::*;
#(
  parameter int TO_CYC = IRQ_TO_MAX_CYC,
  parameter int GAP_CYC = IRQ_GAP_MIN_CYC
)
(
  input wire logic mclk,
  input wire logic rst,
  input sia_src_s src,
  input sia_reg_ctl_s reg_ctl,
  input wire logic [23:0] irq_mask,
  input wire logic mode_active,
  input wire logic init_mode,
  input wire logic reset_out_n,
  input sia_rd_s rd,
  input wire logic irq_pin_in,
  output logic [7:0] rd_data_ff,
  output logic irq_out_ff,
  output logic irq_oe_ff,
  output logic cfg_group_ff
);

  localparam logic [TMR_W-1:0] TO_LAST = TMR_W'(TO_CYC - 1);
  localparam logic [TMR_W-1:0] GAP_LAST = TMR_W'(GAP_CYC - 1);
  // timer equals cycles already held low, so release waits for the full count
  localparam logic [TMR_W-1:0] PULSE_DONE = TMR_W'(IRQ_PULSE_MIN_CYC);

  logic [23:0] live;
  logic [23:0] rise;
  logic [23:0] fall;
  logic [23:0] gate;
  logic [23:0] cmd_set;
  logic [23:0] set;
  logic [23:0] clr;
  logic [23:0] flags_ff;
  logic [23:0] follow_ff;
  logic [23:0] nxt_flags;
  logic any_fail;
  logic unm_evt;
  logic rd_wake;
  logic pending_ff;
  logic rd_seen_ff;
  logic release_now;
  logic cfg_window;
  sia_state_e state_ff;
  sia_state_e nxt_state;
  logic [TMR_W-1:0] tmr_ff;

  always_comb
  begin
    live = '0;
    live[BIT_CAN_WAKE] = src.can_wake;
    live[BIT_LIN_WAKE] = src.lin_wake;
    live[BIT_WK_PIN_WAKE] = src.wk_pin_wake;
    live[BIT_PERIODIC_WAKE] = src.periodic_wake;
    live[BIT_PREWARN] = src.main_reg_temp_prewarn;
    live[BIT_OT2] = src.second_reg_overtemp;
    live[BIT_CAN_OT] = src.can_xcvr_overtemp;
    live[BIT_CAN_FAIL] = src.can_fail;
    live[BIT_LIN_FAIL] = src.lin_fail;
    live[BIT_UV2] = src.second_reg_undervolt & reg_ctl.second_on;
    live[BIT_UV3] = src.third_reg_undervolt & reg_ctl.third_on;
    live[BIT_OC3] = src.third_reg_overcurrent;
    live[BIT_SPI_FAIL] = src.spi_fail;
    live[BIT_RESET_EVT] = src.reset_event;
    live[BIT_BAD_WDOG] = src.bad_wdog_config;
  end

  sia_edge_det #(.W(FLAG_W)) u_edge (
    .mclk(mclk),
    .rst(rst),
    .level(live),
    .rise(rise),
    .fall(fall)
  );

  // an undervoltage edge while the regulator is off is a switch-off, not a failure
  always_comb
  begin
    gate = ~FLAG_DUAL;
    gate[BIT_UV2] = reg_ctl.second_on;
    gate[BIT_UV3] = reg_ctl.third_on;
    cmd_set = '0;
    cmd_set[BIT_UV2] = reg_ctl.second_on_cmd;
    cmd_set[BIT_UV3] = reg_ctl.third_on_cmd;
  end

  assign set = (((rise | (fall & FLAG_DUAL)) & gate) | cmd_set) & FLAG_USED & {FLAG_W{mode_active}};
  assign unm_evt = |(set & irq_mask);
  assign rd_wake = rd.strobe && rd.addr == REG_WAKE;

  genvar i;
  generate
    for (i = 0; i < FLAG_W; i++)
    begin : g_flag
      assign clr[i] = rd.strobe && rd.addr == 3'(i / 8);
      // new event wins over a clear in the same cycle
      assign nxt_flags[i] = set[i] | ((clr[i] || follow_ff[i]) ? (FLAG_LATCH[i] & live[i]) : flags_ff[i]);
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (rst)
      flags_ff <= FLAG_RESET;
    else
      flags_ff <= nxt_flags;
  end

  // once read, a latched-state bit tracks the live condition until its next event
  always_ff @(posedge mclk)
  begin
    if (rst)
      follow_ff <= '0;
    else
      follow_ff <= FLAG_LATCH & ~set & (clr | follow_ff);
  end

  assign any_fail = |flags_ff[23:8];

  always_ff @(posedge mclk)
  begin
    if (rst)
      rd_data_ff <= RD_RESET;
    else if (rd.strobe)
    begin
      unique case (rd.addr)
        REG_WAKE:
        begin
          rd_data_ff <= flags_ff[7:0];
          rd_data_ff[BIT_SUMMARY] <= any_fail;
        end
        REG_FAIL_A: rd_data_ff <= flags_ff[15:8];
        REG_FAIL_B: rd_data_ff <= flags_ff[23:16];
        default: rd_data_ff <= RD_RESET;
      endcase
    end
  end

  // events during the gap are stored here and fire once the gap ends
  always_ff @(posedge mclk)
  begin
    if (rst)
      pending_ff <= 1'b0;
    else if (unm_evt)
      pending_ff <= 1'b1;
    else if (state_ff == S_IDLE)
      pending_ff <= 1'b0;
  end

  assign release_now = (rd_seen_ff || rd_wake) && tmr_ff >= PULSE_DONE;

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      S_IDLE:
        if (pending_ff)
          nxt_state = S_ASSERT;
      S_ASSERT:
        if (release_now || tmr_ff == TO_LAST)
          nxt_state = S_GAP;
      S_GAP:
        if (tmr_ff == GAP_LAST)
          nxt_state = S_IDLE;
      default: nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      state_ff <= S_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge mclk)
  begin
    if (rst || nxt_state != state_ff)
      tmr_ff <= '0;
    else if (state_ff != S_IDLE)
      tmr_ff <= tmr_ff + 1'b1;
  end

  // a read inside the minimum pulse is remembered and honoured at its end
  always_ff @(posedge mclk)
  begin
    if (rst || state_ff != S_ASSERT)
      rd_seen_ff <= 1'b0;
    else if (rd_wake)
      rd_seen_ff <= 1'b1;
  end

  assign cfg_window = init_mode && !reset_out_n;

  // pin is open drain: only ever pulled low, released by dropping the enable
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irq_oe_ff <= 1'b0;
      irq_out_ff <= 1'b0;
    end
    else
    begin
      irq_oe_ff <= nxt_state == S_ASSERT && !cfg_window;
      irq_out_ff <= 1'b0;
    end
  end

  // last level seen before reset output rises is kept as the config group
  always_ff @(posedge mclk)
  begin
    if (rst)
      cfg_group_ff <= 1'b0;
    else if (cfg_window)
      cfg_group_ff <= irq_pin_in;
  end

  sequence s_fresh_event;
    state_ff == S_IDLE && !pending_ff && unm_evt && !cfg_window;
  endsequence

  sequence s_pin_low;
    pending_ff ##1 irq_oe_ff;
  endsequence

  chk_event_pulls_pin: assert property (@(posedge mclk) disable iff (rst)
    s_fresh_event |=> s_pin_low)
    else $error("unmasked event did not pull interrupt low");

  chk_mask_blocks_pin: assert property (@(posedge mclk) disable iff (rst)
    (state_ff == S_IDLE && !pending_ff && |set && !unm_evt) |=> !pending_ff ##1 !irq_oe_ff)
    else $error("masked event asserted interrupt");

  chk_masked_flag_set: assert property (@(posedge mclk) disable iff (rst)
    (set[BIT_SPI_FAIL] && !irq_mask[BIT_SPI_FAIL]) |=> flags_ff[BIT_SPI_FAIL])
    else $error("masked event left status bit clear");

  chk_uv_dual_edge: assert property (@(posedge mclk) disable iff (rst)
    (mode_active && reg_ctl.second_on && fall[BIT_UV2]) |=> flags_ff[BIT_UV2])
    else $error("undervoltage release did not set status");

  chk_latch_then_live: assert property (@(posedge mclk) disable iff (rst)
    (clr[BIT_OT2] && !set[BIT_OT2]) |=> flags_ff[BIT_OT2] == $past(live[BIT_OT2]))
    else $error("latched state bit did not follow live condition after read");

  chk_state_tracks_live: assert property (@(posedge mclk) disable iff (rst)
    (follow_ff[BIT_OT2] && !set[BIT_OT2]) |=> flags_ff[BIT_OT2] == $past(live[BIT_OT2]))
    else $error("state bit did not track live condition after read");

  chk_wake_read_clear: assert property (@(posedge mclk) disable iff (rst)
    (rd_wake && !(|set[3:0])) |=> flags_ff[3:0] == 4'h0 && rd_data_ff[3:0] == $past(flags_ff[3:0]))
    else $error("wake bits not returned and cleared by read");

  chk_event_bit_holds: assert property (@(posedge mclk) disable iff (rst)
    (flags_ff[BIT_BAD_WDOG] && !clr[BIT_BAD_WDOG]) |=> flags_ff[BIT_BAD_WDOG])
    else $error("event bit cleared without read");

  chk_summary_bit: assert property (@(posedge mclk) disable iff (rst)
    rd_wake |=> rd_data_ff[BIT_SUMMARY] == $past(any_fail))
    else $error("summary bit does not match failure registers");

  chk_min_pulse: assert property (@(posedge mclk) disable iff (rst)
    (state_ff == S_ASSERT && tmr_ff < PULSE_DONE) |=> state_ff == S_ASSERT)
    else $error("interrupt pulse shorter than minimum");

  chk_timeout_release: assert property (@(posedge mclk) disable iff (rst)
    (state_ff == S_ASSERT && tmr_ff == TO_LAST) |=> state_ff == S_GAP && !irq_oe_ff)
    else $error("interrupt not released at timeout");

  chk_gap_no_pin: assert property (@(posedge mclk) disable iff (rst)
    (state_ff == S_GAP && tmr_ff < GAP_LAST) |=> !irq_oe_ff)
    else $error("interrupt reasserted inside separation gap");

  chk_read_release: assert property (@(posedge mclk) disable iff (rst)
    (state_ff == S_ASSERT && rd_wake && tmr_ff >= PULSE_DONE) |=> !irq_oe_ff)
    else $error("read of wake register did not release interrupt");

  chk_inactive_mode: assert property (@(posedge mclk) disable iff (rst)
    (!mode_active && !pending_ff && !reg_ctl.second_on_cmd && !reg_ctl.third_on_cmd) |=> !pending_ff)
    else $error("interrupt pending outside normal or stop mode");

  chk_cfg_hold: assert property (@(posedge mclk) disable iff (rst)
    !cfg_window |=> $stable(cfg_group_ff))
    else $error("config group changed outside init window");

endmodule

// [verification/sia_host_model.sv]
`timescale 1ns/1ps
module sia_host_model
  import sia_pkg::*;
(
  input wire logic mclk,
  input wire logic [7:0] rd_data,
  input wire logic irq_oe,
  input wire logic irq_out,
  input wire logic cfg_level,
  output sia_rd_s rd,
  output logic irq_pin_in
);
  // pin follows the strap/pull level unless the device pulls it
  assign irq_pin_in = irq_oe ? irq_out : cfg_level;
  initial rd = '0;
  // one read-only command; dly lets the host answer late
  task automatic rd_reg(input logic [2:0] a, input int dly, output logic [7:0] q);
    repeat (dly) @(negedge mclk);
    @(negedge mclk);
    rd = '{strobe: 1'b1, addr: a};
    @(negedge mclk);
    rd = '{strobe: 1'b0, addr: ~a};
    @(negedge mclk);
    q = rd_data;
  endtask
endmodule

// [verification/sbc_interrupt_aggregator_test.sv]
`timescale 1ns/1ps
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %h got %h", nm, e, a); end end
module sbc_interrupt_aggregator_test
  import sia_pkg::*;
;
  localparam int TO = 300;
  localparam int GAP = 200;
  logic mclk, rst, mode_active, init_mode, reset_out_n, cfg_level;
  logic irq_pin_in, irq_out_ff, irq_oe_ff, cfg_group_ff;
  logic [23:0] irq_mask;
  logic [7:0] rd_data_ff;
  sia_src_s src;
  sia_reg_ctl_s reg_ctl;
  sia_rd_s rd;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;

  sia_irq_core #(.TO_CYC(TO), .GAP_CYC(GAP)) i_sia_irq_core (.mclk(mclk), .rst(rst), .src(src),
    .reg_ctl(reg_ctl), .irq_mask(irq_mask), .mode_active(mode_active), .init_mode(init_mode),
    .reset_out_n(reset_out_n), .rd(rd), .irq_pin_in(irq_pin_in), .rd_data_ff(rd_data_ff),
    .irq_out_ff(irq_out_ff), .irq_oe_ff(irq_oe_ff), .cfg_group_ff(cfg_group_ff));
  sia_host_model i_sia_host_model (.mclk(mclk), .rd_data(rd_data_ff), .irq_oe(irq_oe_ff),
    .irq_out(irq_out_ff), .cfg_level(cfg_level), .rd(rd), .irq_pin_in(irq_pin_in));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // whole run is under two thousand cycles
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic nc(input int k);
    repeat (k) @(negedge mclk);
  endtask

  task automatic rdc(input logic [2:0] a, input logic [7:0] e, input string nm);
    logic [7:0] q;
    i_sia_host_model.rd_reg(a, 0, q);
    `CHK(nm, e, q)
  endtask

  // src bit index: 14 can_wake .. 0 bad_wdog_config
  task automatic pulse(input int b);
    nc(1);
    src[b] = 1'b1;
    nc(1);
    src[b] = 1'b0;
  endtask

  task automatic wait_lvl(input logic v, input int lim, output int k);
    k = 0;
    while (irq_oe_ff !== v && k < lim)
    begin
      nc(1);
      k++;
    end
  endtask

  initial
  begin
    rst = 1'b1;
    src = '0;
    reg_ctl = '{second_on: 1'b1, third_on: 1'b1, second_on_cmd: 1'b0, third_on_cmd: 1'b0};
    irq_mask = FLAG_USED;
    mode_active = 1'b0;
    init_mode = 1'b0;
    reset_out_n = 1'b1;
    cfg_level = 1'b1;
    nc(4);
    rst = 1'b0;
    `CHK("oe_rst", 1'b0, irq_oe_ff)
    rdc(3'h0, 8'h00, "r0_rst");
    rdc(3'h3, 8'h00, "r3_unmapped");
    init_mode = 1'b1;
    reset_out_n = 1'b0;
    nc(3);
    `CHK("cfg_hi", 1'b1, cfg_group_ff)
    cfg_level = 1'b0;
    nc(3);
    `CHK("cfg_lo", 1'b0, cfg_group_ff)
    reset_out_n = 1'b1;
    cfg_level = 1'b1;
    nc(3);
    `CHK("cfg_hold", 1'b0, cfg_group_ff)
    init_mode = 1'b0;
    mode_active = 1'b1;
    // early read must not cut the pulse short
    pulse(2);
    wait_lvl(1'b1, 5, n);
    `CHK("oe_evt", 1'b1, irq_oe_ff)
    `CHK("pin_low", 1'b0, irq_pin_in)
    fork
      rdc(3'h0, 8'h80, "r0_sum");
      wait_lvl(1'b0, 400, n);
    join
    `CHK("min_pulse", 1'b1, n >= IRQ_PULSE_MIN_CYC && n <= IRQ_PULSE_MIN_CYC + 3)
    rdc(3'h0, 8'h80, "r0_sum_keep");
    rdc(3'h2, 8'h08, "r2_spi");
    rdc(3'h2, 8'h00, "r2_clr");
    rdc(3'h0, 8'h00, "r0_sum_clr");
    nc(GAP);
    irq_mask = FLAG_USED & ~24'h100000;
    pulse(1);
    nc(10);
    `CHK("oe_masked", 1'b0, irq_oe_ff)
    rdc(3'h2, 8'h10, "r2_masked");
    irq_mask = FLAG_USED;
    // two wakes at once, a third while asserted, no read: timeout
    nc(1);
    src[14:13] = 2'b11;
    nc(1);
    src[14:13] = 2'b00;
    wait_lvl(1'b1, 5, n);
    fork
      pulse(11);
      wait_lvl(1'b0, TO + 20, n);
    join
    `CHK("to_len", 1'b1, n <= TO && n >= TO - 2)
    wait_lvl(1'b1, GAP + 20, n);
    `CHK("gap_len", 1'b1, n >= GAP && n <= GAP + 4)
    fork
      rdc(3'h0, 8'h0b, "r0_wakes");
      wait_lvl(1'b0, 400, n);
    join
    rdc(3'h0, 8'h00, "r0_wake_clr");
    nc(GAP);
    irq_mask = '0;
    pulse(7);
    nc(2);
    rdc(3'h1, 8'h08, "r1_canf_latch");
    rdc(3'h1, 8'h00, "r1_canf_clr");
    src[9] = 1'b1;
    nc(3);
    rdc(3'h1, 8'h02, "r1_ot_latch");
    rdc(3'h1, 8'h02, "r1_ot_live");
    `CHK("oe_mask0", 1'b0, irq_oe_ff)
    src[9] = 1'b0;
    nc(2);
    rdc(3'h1, 8'h00, "r1_ot_gone");
    mode_active = 1'b0;
    pulse(12);
    nc(2);
    rdc(3'h0, 8'h00, "r0_inactive");
    mode_active = 1'b1;
    pulse(12);
    nc(2);
    rdc(3'h0, 8'h04, "r0_rearm");
    src[5] = 1'b1;
    nc(3);
    rdc(3'h2, 8'h01, "r2_uv_rise");
    rdc(3'h2, 8'h01, "r2_uv_live");
    src[5] = 1'b0;
    nc(3);
    rdc(3'h2, 8'h01, "r2_uv_fall");
    rdc(3'h2, 8'h00, "r2_uv_clr");
    reg_ctl.second_on_cmd = 1'b1;
    nc(1);
    reg_ctl.second_on_cmd = 1'b0;
    nc(2);
    rdc(3'h2, 8'h01, "r2_sw_on");
    rdc(3'h2, 8'h00, "r2_sw_clr");
    // switch-off dip must stay silent even unmasked
    irq_mask = FLAG_USED;
    reg_ctl.second_on = 1'b0;
    src[5] = 1'b1;
    nc(3);
    src[5] = 1'b0;
    nc(GAP);
    `CHK("oe_sw_off", 1'b0, irq_oe_ff)
    reg_ctl.third_on_cmd = 1'b1;
    nc(1);
    reg_ctl.third_on_cmd = 1'b0;
    wait_lvl(1'b1, 5, n);
    `CHK("oe_sw_on", 1'b1, irq_oe_ff)
    // late read: pin released on the edge that takes it
    fork
      begin
        nc(110);
        rdc(3'h0, 8'h80, "r0_sum_uv");
      end
      wait_lvl(1'b0, 400, n);
    join
    `CHK("late_rd_rel", 1'b1, n == 112)
    rdc(3'h2, 8'h02, "r2_uv3_on");
    test_done();
  end
endmodule
